/* File: design/adp_ctrl.sv */
// Mode, serial control word and protection logic of the multi-output actuator driver
`timescale 1ns/1ps

// Function
// - Bits 12 and 13 zero select standby
// - Standby clears latched data, outputs off
// - Bit 12 or 13 high selects active
// - Reset initialises; logic undervoltage clears status
// - Flags set only after filter time
// - Open load and warning only flag
// - Overload kills driver; shutdown kills all
// - Faulted driver stays off until flag cleared
// - Supply overvoltage forces outputs off
// - Supply undervoltage off until supply, pump recover
// - Lockout bit blocks automatic restart
// - Junction warning sets readable flag
// - Shutdown flag kills outputs until cleared
// - Open load flags in status one
// - Overcurrent flags in status zero, driver off
// - Bits 12, 13 select current monitor source
// - Control word sets each bridge mode
// - Sixteen bit word, LSB first
// - Serial ignored while chip select high
// - Data out tristate while deselected
module adp_ctrl #(
  parameter int SLOW_FILTER_CYCLES = adp_pkg::SLOW_FILTER_CYCLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          chip_select_low,
  input  wire logic                          spi_clk,
  input  wire logic                          spi_di,
  output logic                               spi_do,
  output logic                               spi_do_oe,
  input  wire logic [adp_pkg::SW_COUNT-1:0]  over_current,
  input  wire logic [adp_pkg::SW_COUNT-1:0]  open_load,
  input  wire logic                          temp_warn,
  input  wire logic                          temp_shut,
  input  wire logic                          supply_over,
  input  wire logic                          supply_under,
  input  wire logic                          pump_ready,
  input  wire logic                          logic_under,
  output logic [adp_pkg::SW_COUNT-1:0]       switch_on,
  output logic [1:0]                         monitor_sel,
  output logic                               standby
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [adp_pkg::IN_W-1:0] in_s1;
  logic [adp_pkg::IN_W-1:0] in_s2;
  logic [adp_pkg::IN_W-1:0] in_s3;
  logic [adp_pkg::IN_W-1:0] in_st;

  // A change counts only once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_s1 <= adp_pkg::IN_RESET;
      in_s2 <= adp_pkg::IN_RESET;
      in_s3 <= adp_pkg::IN_RESET;
      in_st <= adp_pkg::IN_RESET;
    end else begin
      in_s1 <= {logic_under, pump_ready, supply_under, supply_over, temp_shut, temp_warn,
                open_load, over_current, spi_di, spi_clk, chip_select_low};
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      in_st <= (in_s2 & in_s3) | (in_st & (in_s2 ^ in_s3));
    end
  end

  logic                         cs_st;
  logic                         sck_st;
  logic                         di_st;
  logic [adp_pkg::SW_COUNT-1:0] oc_st;
  logic [adp_pkg::SW_COUNT-1:0] ol_st;
  logic                         vcc_uv_st;
  logic                         cp_st;

  assign cs_st     = in_st[adp_pkg::IN_CS];
  assign sck_st    = in_st[adp_pkg::IN_SCK];
  assign di_st     = in_st[adp_pkg::IN_DI];
  assign oc_st     = in_st[adp_pkg::IN_OC_LSB +: adp_pkg::SW_COUNT];
  assign ol_st     = in_st[adp_pkg::IN_OL_LSB +: adp_pkg::SW_COUNT];
  assign vcc_uv_st = in_st[adp_pkg::IN_VCCUV];
  assign cp_st     = in_st[adp_pkg::IN_CP];

  // ----------------------------------------------------------------
  // Serial receiver and transmitter
  // ----------------------------------------------------------------
  logic                          cs_prev;
  logic                          sck_prev;
  logic [adp_pkg::WORD_BITS-1:0] rx_shift;
  logic [adp_pkg::CNT_W-1:0]     bit_cnt;
  logic [adp_pkg::WORD_BITS-1:0] tx_shift;
  logic                          word_done;
  logic [adp_pkg::WORD_BITS-1:0] word;
  logic [adp_pkg::WORD_BITS-1:0] status_out;
  logic                          sck_rise;
  logic                          cs_fall;
  logic                          cs_rise;

  assign sck_rise = sck_st & ~sck_prev & ~cs_st;
  assign cs_fall  = ~cs_st & cs_prev;
  assign cs_rise  = cs_st & ~cs_prev;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev  <= 1'b1;
      sck_prev <= 1'b0;
    end else begin
      cs_prev  <= cs_st;
      sck_prev <= sck_st;
    end
  end

  // First bit in lands in bit 0 after sixteen shifts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= adp_pkg::WORD_RESET;
      bit_cnt  <= adp_pkg::CNT_ZERO;
    end else if (cs_fall) begin
      bit_cnt  <= adp_pkg::CNT_ZERO;
    end else if (sck_rise) begin
      rx_shift <= {di_st, rx_shift[adp_pkg::WORD_BITS-1:1]};
      if (bit_cnt != adp_pkg::CNT_SAT) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  // Frames of any other length are dropped whole
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_done <= 1'b0;
      word      <= adp_pkg::WORD_RESET;
    end else begin
      word_done <= cs_rise && (bit_cnt == adp_pkg::CNT_FULL);
      word      <= rx_shift;
    end
  end

  // Next bit goes out after each rising edge; host samples at the end of the low phase, before the next rising edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift  <= adp_pkg::WORD_RESET;
      spi_do    <= 1'b0;
      spi_do_oe <= 1'b0;
    end else begin
      spi_do_oe <= ~cs_st;
      if (cs_fall) begin
        tx_shift <= status_out;
        spi_do   <= status_out[0];
      end else if (sck_rise) begin
        tx_shift <= {1'b0, tx_shift[adp_pkg::WORD_BITS-1:1]};
        spi_do   <= tx_shift[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode and control word
  // ----------------------------------------------------------------
  adp_pkg::adp_mode_t            mode;
  logic [adp_pkg::WORD_BITS-1:0] ctrl;
  logic                          word_standby;
  logic                          clr_flags;
  logic                          run;

  assign word_standby = (word[adp_pkg::CW_MUX_MSB:adp_pkg::CW_MUX_LSB] == adp_pkg::MUX_STANDBY);
  assign clr_flags    = word_done & (word[adp_pkg::CW_CLEAR] | word_standby);
  assign run          = (mode == adp_pkg::ADP_ACTIVE) & ~vcc_uv_st;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode <= adp_pkg::ADP_STANDBY;
      ctrl <= adp_pkg::WORD_RESET;
    end else if (word_done) begin
      case (word_standby)
        1'b1: begin
          mode <= adp_pkg::ADP_STANDBY;
          ctrl <= adp_pkg::WORD_RESET;
        end
        1'b0: begin
          mode <= adp_pkg::ADP_ACTIVE;
          ctrl <= word;
        end
        default: begin
          mode <= adp_pkg::ADP_STANDBY;
          ctrl <= adp_pkg::WORD_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic filters
  // ----------------------------------------------------------------
  logic [adp_pkg::SW_COUNT-1:0] oc_hit;
  logic [adp_pkg::SW_COUNT-1:0] ol_hit;
  logic                         warn_hit;
  logic                         shut_hit;
  logic                         ov_hit;
  logic                         uv_hit;

  for (genvar i = 0; i < adp_pkg::SW_COUNT; i++) begin : g_sw_filt
    adp_diag_filter #(.CYCLES(adp_pkg::OC_FILTER_CYCLES)) u_oc (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .enable  (run),
      .cond    (oc_st[i]),
      .hit     (oc_hit[i])
    );
    adp_diag_filter #(.CYCLES(SLOW_FILTER_CYCLES)) u_ol (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .enable  (run),
      .cond    (ol_st[i]),
      .hit     (ol_hit[i])
    );
  end

  for (genvar j = 0; j < 4; j++) begin : g_glob_filt
    logic hit_j;
    adp_diag_filter #(.CYCLES(SLOW_FILTER_CYCLES)) u_glob (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .enable  (run),
      .cond    (in_st[adp_pkg::IN_WARN + j]),
      .hit     (hit_j)
    );
  end

  assign warn_hit = g_glob_filt[0].hit_j;
  assign shut_hit = g_glob_filt[1].hit_j;
  assign ov_hit   = g_glob_filt[2].hit_j;
  assign uv_hit   = g_glob_filt[3].hit_j;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic [adp_pkg::SW_COUNT-1:0] oc_flag;
  logic [adp_pkg::SW_COUNT-1:0] ol_flag;
  logic                         warn_flag;
  logic                         tsd_flag;
  logic                         ov_flag;
  logic                         uv_flag;

  // Set wins over a clear landing in the same cycle; shutdown re-sets while still hot
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oc_flag   <= adp_pkg::SW_OFF;
      ol_flag   <= adp_pkg::SW_OFF;
      warn_flag <= 1'b0;
      tsd_flag  <= 1'b0;
      ov_flag   <= 1'b0;
      uv_flag   <= 1'b0;
    end else if (vcc_uv_st) begin
      oc_flag   <= adp_pkg::SW_OFF;
      ol_flag   <= adp_pkg::SW_OFF;
      warn_flag <= 1'b0;
      tsd_flag  <= 1'b0;
      ov_flag   <= 1'b0;
      uv_flag   <= 1'b0;
    end else begin
      oc_flag   <= (oc_flag & ~{adp_pkg::SW_COUNT{clr_flags}}) | oc_hit;
      ol_flag   <= (ol_flag & ~{adp_pkg::SW_COUNT{clr_flags}}) | ol_hit;
      warn_flag <= (warn_flag & ~clr_flags) | warn_hit;
      tsd_flag  <= (tsd_flag & ~clr_flags) | shut_hit;
      ov_flag   <= (ov_flag & ~clr_flags) | ov_hit;
      uv_flag   <= (uv_flag & ~clr_flags) | uv_hit;
    end
  end

  function automatic logic [adp_pkg::WORD_BITS-1:0] status_word(
    input logic [adp_pkg::SW_COUNT-1:0] flags,
    input logic                         supply
  );
    logic [adp_pkg::WORD_BITS-1:0] w;
    w                                             = adp_pkg::WORD_RESET;
    w[adp_pkg::ST_ACTIVE]                         = (mode == adp_pkg::ADP_ACTIVE);
    w[adp_pkg::CW_SW_MSB:adp_pkg::CW_SW_LSB]      = flags;
    w[adp_pkg::ST_WARN]                           = warn_flag;
    w[adp_pkg::ST_TSD]                            = tsd_flag;
    w[adp_pkg::ST_SUPPLY]                         = supply;
    return w;
  endfunction : status_word

  assign status_out = ctrl[adp_pkg::CW_STAT_SEL] ? status_word(ol_flag, uv_flag)
                                                 : status_word(oc_flag, ov_flag);

  // ----------------------------------------------------------------
  // Supply recovery and driver gating
  // ----------------------------------------------------------------
  logic                         uv_wait;
  logic                         lockout;
  logic                         block_all;
  logic [adp_pkg::SW_COUNT-1:0] next_switch_on;

  assign lockout = ctrl[adp_pkg::CW_LOCKOUT];

  // Undervoltage recovery also waits for the charge pump
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      uv_wait <= 1'b0;
    end else if (uv_hit) begin
      uv_wait <= 1'b1;
    end else if (cp_st) begin
      uv_wait <= 1'b0;
    end
  end

  assign block_all = ~run | tsd_flag
                   | ov_hit | (lockout & ov_flag)
                   | uv_hit | uv_wait | (lockout & uv_flag);

  // Both switches of one half bridge on would short the supply
  always_comb begin
    next_switch_on = ctrl[adp_pkg::CW_SW_MSB:adp_pkg::CW_SW_LSB] & ~oc_flag;
    for (int k = 0; k < adp_pkg::HALF_COUNT; k++) begin
      if (next_switch_on[2*k] && next_switch_on[2*k+1]) begin
        next_switch_on[2*k]   = 1'b0;
        next_switch_on[2*k+1] = 1'b0;
      end
    end
    if (block_all) begin
      next_switch_on = adp_pkg::SW_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      switch_on   <= adp_pkg::SW_OFF;
      monitor_sel <= adp_pkg::MUX_STANDBY;
      standby     <= 1'b1;
    end else begin
      switch_on   <= next_switch_on;
      monitor_sel <= ctrl[adp_pkg::CW_MUX_MSB:adp_pkg::CW_MUX_LSB];
      standby     <= (mode == adp_pkg::ADP_STANDBY);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence seq_word_standby;
    word_done && word_standby;
  endsequence

  sequence seq_word_active;
    word_done && !word_standby;
  endsequence

  chk_standby_entry: assert property (
    seq_word_standby |=> (ctrl == adp_pkg::WORD_RESET) ##1 (standby && switch_on == adp_pkg::SW_OFF))
    else $error("standby word did not clear control and outputs");

  chk_active_entry: assert property (
    seq_word_active |=> ##1 !standby)
    else $error("active word did not leave standby");

  chk_monitor_select: assert property (
    seq_word_active |=> ##1 (monitor_sel == $past(word[adp_pkg::CW_MUX_MSB:adp_pkg::CW_MUX_LSB], 2)))
    else $error("monitor select does not follow control word");

  chk_logic_under_clear: assert property (
    vcc_uv_st |=> (oc_flag == adp_pkg::SW_OFF && !tsd_flag && !ov_flag && switch_on == adp_pkg::SW_OFF))
    else $error("logic undervoltage did not clear status");

  chk_flag_after_filter: assert property (
    $changed(oc_flag) |-> ((oc_flag & ~$past(oc_flag) & ~$past(oc_hit)) == adp_pkg::SW_OFF))
    else $error("overcurrent flag set without filtered condition");

  chk_filter_restart: assert property (
    !ol_st[0] |=> !ol_hit[0])
    else $error("open load filter did not restart");

  chk_overload_off: assert property (
    (oc_flag != adp_pkg::SW_OFF) |=> ((switch_on & $past(oc_flag)) == adp_pkg::SW_OFF))
    else $error("overloaded driver still on");

  chk_shutdown_all_off: assert property (
    tsd_flag |=> (switch_on == adp_pkg::SW_OFF))
    else $error("driver on during thermal shutdown");

  chk_over_voltage_off: assert property (
    ov_hit |=> (switch_on == adp_pkg::SW_OFF))
    else $error("driver on during supply overvoltage");

  chk_under_voltage_off: assert property (
    (uv_hit || uv_wait) |=> (switch_on == adp_pkg::SW_OFF))
    else $error("driver on before supply and pump recovered");

  chk_lockout_hold: assert property (
    (lockout && (ov_flag || uv_flag)) |=> (switch_on == adp_pkg::SW_OFF))
    else $error("lockout did not hold drivers off");

  chk_do_tristate: assert property (
    cs_st |=> !spi_do_oe)
    else $error("data out driven while deselected");

  chk_short_frame: assert property (
    (cs_rise && bit_cnt != adp_pkg::CNT_FULL && !word_done) |=> ##1 $stable(ctrl))
    else $error("control word taken from a bad frame");

endmodule : adp_ctrl

/* File: design/adp_pkg.sv */
// Shared constants and types of the actuator driver protection controller
package adp_pkg;

  // ----------------------------------------------------------------
  // Clock and filter timing
  // ----------------------------------------------------------------
  localparam int  CLK_MHZ             = 125;
  localparam int  OC_FILTER_TIME_US   = 10;
  localparam real SLOW_FILTER_TIME_MS = 0.5;
  localparam int  OC_FILTER_CYCLES    = OC_FILTER_TIME_US * CLK_MHZ;
  localparam int  SLOW_FILTER_CYCLES  = int'($ceil(SLOW_FILTER_TIME_MS * 1000.0 * CLK_MHZ));
  localparam int  FILT_W              = 16;

  // ----------------------------------------------------------------
  // Serial control word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS   = 16;
  localparam int SW_COUNT    = 11;
  localparam int HALF_COUNT  = 5;
  localparam int CW_STAT_SEL = 0;
  localparam int CW_SW_LSB   = 1;
  localparam int CW_SW_MSB   = 11;
  localparam int CW_MUX_LSB  = 12;
  localparam int CW_MUX_MSB  = 13;
  localparam int CW_LOCKOUT  = 14;
  localparam int CW_CLEAR    = 15;

  localparam logic [1:0] MUX_STANDBY = 2'h0;

  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic [SW_COUNT-1:0]  SW_OFF     = 11'h000;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int ST_ACTIVE = 0;
  localparam int ST_WARN   = 12;
  localparam int ST_TSD    = 13;
  localparam int ST_SUPPLY = 14;

  // ----------------------------------------------------------------
  // Bit counter
  // ----------------------------------------------------------------
  localparam int         CNT_W    = 5;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_SAT  = 5'h1f;

  // ----------------------------------------------------------------
  // Layout of the synchronised input vector
  // ----------------------------------------------------------------
  localparam int IN_CS     = 0;
  localparam int IN_SCK    = 1;
  localparam int IN_DI     = 2;
  localparam int IN_OC_LSB = 3;
  localparam int IN_OL_LSB = 14;
  localparam int IN_WARN   = 25;
  localparam int IN_SHUT   = 26;
  localparam int IN_OV     = 27;
  localparam int IN_UV     = 28;
  localparam int IN_CP     = 29;
  localparam int IN_VCCUV  = 30;
  localparam int IN_W      = 31;

  localparam logic [IN_W-1:0] IN_RESET = 31'h0000_0001;

  typedef enum logic {
    ADP_STANDBY = 1'b0,
    ADP_ACTIVE  = 1'b1
  } adp_mode_t;

endpackage : adp_pkg

/* File: design/adp_diag_filter.sv */
// Persistence filter for one diagnostic condition
`timescale 1ns/1ps

module adp_diag_filter #(
  parameter int CYCLES = 1
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic cond,
  output logic      hit
);

  localparam logic [adp_pkg::FILT_W-1:0] LAST = adp_pkg::FILT_W'(CYCLES - 1);

  logic [adp_pkg::FILT_W-1:0] count;

  // Any gap in the condition restarts the count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      hit   <= 1'b0;
    end else if (!enable || !cond) begin
      count <= '0;
      hit   <= 1'b0;
    end else if (count == LAST) begin
      hit   <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule : adp_diag_filter

/* File: bench/adp_host_model.sv */
// Serial host model that drives the actuator controller's control link
`timescale 1ns/1ps

module adp_host_model (
  input  wire logic clk_sys,
  output logic      chip_select_low,
  output logic      spi_clk,
  output logic      spi_di,
  input  wire logic spi_do,
  input  wire logic spi_do_oe
);
  initial begin
    chip_select_low = 1'b1;
    spi_clk         = 1'b0;
    spi_di          = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame transfer
  // ----------------------------------------------------------------
  // Status bit taken at the end of each low phase, well after it settles
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] st);
    st = 16'h0000;
    @(posedge clk_sys);
    chip_select_low <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      spi_di <= w[i];
      repeat (4) @(posedge clk_sys);
      if (i < 16) st[i] = spi_do & spi_do_oe;
      spi_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      spi_clk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    chip_select_low <= 1'b1;
    // Released line shows a changed level, not the last bit
    spi_di <= ~spi_di;
    repeat (12) @(posedge clk_sys);
  endtask : xfer
endmodule : adp_host_model

/* File: bench/adp_ctrl_bench.sv */
// Self-checking bench of the actuator driver protection controller
`timescale 1ns/1ps

module adp_ctrl_bench;
  localparam int          SLOW = 20;
  localparam logic [10:0] SW_A = 11'h049;

  logic        clk_sys;
  logic        rst_n;
  logic        chip_select_low;
  logic        spi_clk;
  logic        spi_di;
  logic        spi_do;
  logic        spi_do_oe;
  logic [10:0] over_current;
  logic [10:0] open_load;
  logic        temp_warn, temp_shut, supply_over, supply_under, pump_ready, logic_under;
  logic [10:0] switch_on;
  logic [1:0]  monitor_sel;
  logic        standby;
  logic [15:0] st;
  int          n_mismatch;
  int          n_compared;

  adp_ctrl #(.SLOW_FILTER_CYCLES(SLOW)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .chip_select_low(chip_select_low), .spi_clk(spi_clk),
    .spi_di(spi_di), .spi_do(spi_do), .spi_do_oe(spi_do_oe), .over_current(over_current),
    .open_load(open_load), .temp_warn(temp_warn), .temp_shut(temp_shut), .supply_over(supply_over),
    .supply_under(supply_under), .pump_ready(pump_ready), .logic_under(logic_under),
    .switch_on(switch_on), .monitor_sel(monitor_sel), .standby(standby)
  );

  adp_host_model u_host (
    .clk_sys(clk_sys), .chip_select_low(chip_select_low), .spi_clk(spi_clk),
    .spi_di(spi_di), .spi_do(spi_do), .spi_do_oe(spi_do_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] mk(logic [10:0] sw, logic [1:0] mux, logic lock, logic clr, logic sel);
    return {clr, lock, mux, sw, sel};
  endfunction : mk

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic send(input logic [15:0] w);
    u_host.xfer(w, 16, st);
  endtask : send

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_modes();
    chk("standby", standby, 1);
    chk("oe", spi_do_oe, 0);
    for (int m = 1; m < 4; m++) begin
      send(mk(SW_A, m[1:0], 0, 0, 0));
      chk("mux", monitor_sel, m[1:0]);
      chk("standby", standby, 0);
      chk("sw", switch_on, SW_A);
      chk("oe", spi_do_oe, 0);
    end
    // Short frame must leave everything untouched
    u_host.xfer(mk(11'h000, 2'h0, 0, 0, 0), 15, st);
    chk("sw", switch_on, SW_A);
  endtask : t_modes

  task automatic t_overcurrent();
    for (int k = 0; k < 2; k++) begin
      over_current <= 11'h008;
      idle(1000);
      over_current <= 11'h000;
      // Gap must outlast the input filter that needs stages two and three to agree
      idle(4);
    end
    chk("sw", switch_on, SW_A);
    over_current <= 11'h008;
    idle(1200);
    chk("sw", switch_on, SW_A);
    idle(100);
    chk("sw", switch_on, SW_A & 11'h7f7);
    over_current <= 11'h000;
    idle(20);
    chk("sw", switch_on, SW_A & 11'h7f7);
    send(mk(SW_A, 1, 0, 0, 1));
    chk("status0", st, 16'h0011);
    send(mk(SW_A, 1, 0, 1, 0));
    chk("sw", switch_on, SW_A);
  endtask : t_overcurrent

  task automatic t_openload();
    send(mk(SW_A, 1, 0, 0, 1));
    open_load <= 11'h7ff;
    temp_warn <= 1'b1;
    idle(40);
    chk("sw", switch_on, SW_A);
    send(mk(SW_A, 1, 0, 0, 1));
    chk("status1", st, 16'h1fff);
    open_load <= 11'h000;
    temp_warn <= 1'b0;
    idle(10);
    send(mk(SW_A, 1, 0, 1, 0));
  endtask : t_openload

  task automatic t_thermal();
    temp_shut <= 1'b1;
    idle(40);
    chk("sw", switch_on, 16'h0000);
    send(mk(SW_A, 1, 0, 1, 0));
    chk("sw", switch_on, 16'h0000);
    temp_shut <= 1'b0;
    idle(10);
    chk("sw", switch_on, 16'h0000);
    send(mk(SW_A, 1, 0, 1, 0));
    chk("sw", switch_on, SW_A);
  endtask : t_thermal

  task automatic t_supply();
    supply_over <= 1'b1;
    idle(40);
    chk("sw", switch_on, 16'h0000);
    supply_over <= 1'b0;
    idle(40);
    chk("sw", switch_on, SW_A);
    pump_ready   <= 1'b0;
    supply_under <= 1'b1;
    idle(40);
    chk("sw", switch_on, 16'h0000);
    supply_under <= 1'b0;
    idle(40);
    chk("sw", switch_on, 16'h0000);
    pump_ready <= 1'b1;
    idle(40);
    chk("sw", switch_on, SW_A);
    // Lockout set and old flags cleared before the next fault
    send(mk(SW_A, 1, 1, 1, 0));
    chk("sw", switch_on, SW_A);
    supply_over <= 1'b1;
    idle(40);
    supply_over <= 1'b0;
    idle(40);
    chk("sw", switch_on, 16'h0000);
    send(mk(SW_A, 1, 1, 1, 0));
    chk("sw", switch_on, SW_A);
  endtask : t_supply

  task automatic t_standby();
    logic_under <= 1'b1;
    idle(10);
    chk("sw", switch_on, 16'h0000);
    logic_under <= 1'b0;
    idle(10);
    chk("sw", switch_on, SW_A);
    send(mk(SW_A, 0, 0, 0, 0));
    chk("standby", standby, 1);
    chk("sw", switch_on, 16'h0000);
    chk("mux", monitor_sel, 16'h0000);
    send(mk(11'h000, 2, 0, 0, 0));
    chk("standby", standby, 0);
  endtask : t_standby

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    n_mismatch   = 0;
    n_compared   = 0;
    rst_n        = 1'b0;
    over_current = 11'h000;
    open_load    = 11'h000;
    temp_warn    = 1'b0;
    temp_shut    = 1'b0;
    supply_over  = 1'b0;
    supply_under = 1'b0;
    pump_ready   = 1'b1;
    logic_under  = 1'b0;
    idle(4);
    rst_n <= 1'b1;
    idle(6);
    t_modes();
    t_overcurrent();
    t_openload();
    t_thermal();
    t_supply();
    t_standby();
    give_verdict();
  end

  // Whole run needs under 10000 cycles
  initial begin
    idle(40000);
    n_mismatch++;
    give_verdict();
  end
endmodule : adp_ctrl_bench
